// ---- design/tpd_detector.sv ----
`timescale 1ns/1ns
// How it works
// - Abort bit 0: pulses seen during latency do not stop double detection.
// - Abort bit 1: pulse starting and ending inside latency aborts double detection.
// - Latch bit 1 holds flags until source read; 0 lets them follow events.
// - Per-axis single-pulse enable gates the single event flag.
// - Per-axis double-pulse enable gates the double event flag.
// - Summary active bit reads 1 once any enabled event has fired.
// - Per-axis flag set for each enabled axis that took part in the event.
// - Pulse-type bit reads 1 for a double event, 0 for single.
// - Per-axis polarity bit: 0 positive pulse, 1 negative pulse.
// - Thresholds are unsigned 7-bit counts of 63 mg.
// - Comparison scaled to 8 g whatever the data range setting.
// - Crossing an axis threshold starts the pulse procedure.
// - X and Y thresholds in bits 6..0, top bit reads zero.
// - Z threshold has the same format in its own register.
// - Time limit bounds how long a pulse may stay above threshold.
// - Latency after the first pulse ignores any new pulse start while the abort bit is 0.
module tpd_detector
    import tpd_pkg::*;
#(
    parameter int DATA_W = 14
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sample_valid,
    input wire logic signed [DATA_W-1:0] accel_x,
    input wire logic signed [DATA_W-1:0] accel_y,
    input wire logic signed [DATA_W-1:0] accel_z,
    input wire logic [1:0] accel_full_scale,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic pulse_irq
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] thx;
        logic [7:0] thy;
        logic [7:0] thz;
        logic [7:0] tml;
        logic [7:0] ltc;
        logic [7:0] win;
        logic [7:0] src;
        tpd_state_t st;
        logic [7:0] cnt;
        logic [2:0] ax;
        logic [2:0] pol;
        logic seen;
        logic [7:0] rdata;
        logic irq;
    } tpd_regs_t;

    tpd_regs_t r;
    tpd_regs_t next_r;

    logic [2:0] above;
    logic [2:0] neg;
    logic [2:0] sp_en;
    logic [2:0] dp_en;

    // Magnitude in mg at 8 g scale
    function automatic logic [DATA_W:0] tpd_mg(
        input logic signed [DATA_W-1:0] a,
        input logic [1:0] fs
    );
        logic [DATA_W:0] m;
        m = a[DATA_W-1] ? (DATA_W+1)'(-a) : (DATA_W+1)'(a);
        if (fs == TPD_FS_2G) begin
            m = m >> 2;
        end else if (fs == TPD_FS_4G) begin
            m = m >> 1;
        end
        return m;
    endfunction

    // Threshold in mg from 7-bit count
    function automatic logic [DATA_W:0] tpd_thr(input logic [7:0] t);
        // Widen both factors first so the product cannot wrap
        return (DATA_W+1)'(t[6:0]) * (DATA_W+1)'(TPD_MG_PER_LSB);
    endfunction

    // Per-axis compare and sign
    always_comb begin
        above[0] = tpd_mg(accel_x, accel_full_scale) > tpd_thr(r.thx);
        above[1] = tpd_mg(accel_y, accel_full_scale) > tpd_thr(r.thy);
        above[2] = tpd_mg(accel_z, accel_full_scale) > tpd_thr(r.thz);
        neg = {accel_z[DATA_W-1], accel_y[DATA_W-1], accel_x[DATA_W-1]};
        sp_en = {r.cfg[4], r.cfg[2], r.cfg[0]};
        dp_en = {r.cfg[5], r.cfg[3], r.cfg[1]};
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic [2:0] hit;
        logic dbl;
        logic rd_src;
        hit = 3'h0;
        dbl = 1'b0;
        rd_src = reg_rd && reg_addr == TPD_OFS_SRC;
        next_r = r;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                TPD_OFS_CFG: next_r.cfg = reg_wdata;
                TPD_OFS_THX: next_r.thx = reg_wdata & TPD_THR_MASK;
                TPD_OFS_THY: next_r.thy = reg_wdata & TPD_THR_MASK;
                TPD_OFS_THZ: next_r.thz = reg_wdata & TPD_THR_MASK;
                TPD_OFS_TML: next_r.tml = reg_wdata;
                TPD_OFS_LTC: next_r.ltc = reg_wdata;
                TPD_OFS_WIN: next_r.win = reg_wdata;
                default: ;
            endcase
        end

        // Register reads, answered next cycle
        if (reg_rd) begin
            unique case (reg_addr)
                TPD_OFS_CFG: next_r.rdata = r.cfg;
                TPD_OFS_SRC: next_r.rdata = r.src;
                TPD_OFS_THX: next_r.rdata = r.thx;
                TPD_OFS_THY: next_r.rdata = r.thy;
                TPD_OFS_THZ: next_r.rdata = r.thz;
                TPD_OFS_TML: next_r.rdata = r.tml;
                TPD_OFS_LTC: next_r.rdata = r.ltc;
                TPD_OFS_WIN: next_r.rdata = r.win;
                default: next_r.rdata = 8'h00;
            endcase
        end

        // Reading the source clears it
        if (rd_src) begin
            next_r.src = 8'h00;
        end

        // Detector advances once per data period
        if (sample_valid) begin
            // Unlatched flags last one data period
            if (!r.cfg[TPD_CFG_LATCH]) begin
                next_r.src = 8'h00;
            end
            unique case (r.st)
                TPD_IDLE: begin
                    if (|above) begin
                        next_r.st = TPD_FIRST;
                        next_r.cnt = 8'h00;
                        next_r.ax = above;
                        next_r.pol = neg;
                    end
                end
                TPD_FIRST: begin
                    if (|(above & r.ax)) begin
                        next_r.cnt = r.cnt + 8'h01;
                        if (r.cnt >= r.tml) begin
                            next_r.st = TPD_IDLE;
                        end
                    end else begin
                        hit = r.ax & sp_en;
                        next_r.cnt = 8'h00;
                        next_r.seen = 1'b0;
                        next_r.st = |(r.ax & dp_en) ? TPD_LATENCY : TPD_IDLE;
                    end
                end
                TPD_LATENCY: begin
                    // New starts are ignored here while the abort bit is clear
                    next_r.cnt = r.cnt + 8'h01;
                    if (|above) begin
                        next_r.seen = 1'b1;
                    end
                    if (r.cfg[TPD_CFG_ABORT] && r.seen && !(|above)) begin
                        next_r.st = TPD_IDLE;
                    end else if (r.cnt >= r.ltc) begin
                        next_r.st = TPD_WINDOW;
                        next_r.cnt = 8'h00;
                    end
                end
                TPD_WINDOW: begin
                    if (|(above & r.ax)) begin
                        next_r.st = TPD_SECOND;
                        next_r.cnt = 8'h00;
                        next_r.pol = neg;
                    end else begin
                        next_r.cnt = r.cnt + 8'h01;
                        if (r.cnt >= r.win) begin
                            next_r.st = TPD_IDLE;
                        end
                    end
                end
                TPD_SECOND: begin
                    if (|(above & r.ax)) begin
                        next_r.cnt = r.cnt + 8'h01;
                        if (r.cnt >= r.tml) begin
                            next_r.st = TPD_IDLE;
                        end
                    end else begin
                        hit = r.ax & dp_en;
                        dbl = 1'b1;
                        next_r.st = TPD_IDLE;
                    end
                end
            endcase
        end

        // Report an event; set wins over the read clear
        if (|hit) begin
            if (!(r.cfg[TPD_CFG_LATCH] && r.src[TPD_SRC_ANY] && !rd_src)) begin
                next_r.src[TPD_SRC_ANY] = 1'b1;
                next_r.src[TPD_SRC_AX +: 3] = hit;
                next_r.src[TPD_SRC_DBL] = dbl;
                next_r.src[TPD_SRC_POL +: 3] = r.pol & hit;
            end
        end

        next_r.irq = next_r.src[TPD_SRC_ANY];
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '{cfg: TPD_RST_REG, thx: TPD_RST_REG, thy: TPD_RST_REG,
                   thz: TPD_RST_REG, tml: TPD_RST_REG, ltc: TPD_RST_REG,
                   win: TPD_RST_WIN, src: TPD_RST_REG, st: TPD_IDLE,
                   cnt: 8'h00, ax: 3'h0, pol: 3'h0, seen: 1'b0,
                   rdata: 8'h00, irq: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign pulse_irq = r.irq;

endmodule

// ---- design/tpd_pkg.sv ----
package tpd_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] TPD_OFS_CFG = 8'h21;
    localparam logic [7:0] TPD_OFS_SRC = 8'h22;
    localparam logic [7:0] TPD_OFS_THX = 8'h23;
    localparam logic [7:0] TPD_OFS_THY = 8'h24;
    localparam logic [7:0] TPD_OFS_THZ = 8'h25;
    localparam logic [7:0] TPD_OFS_TML = 8'h26;
    localparam logic [7:0] TPD_OFS_LTC = 8'h27;
    localparam logic [7:0] TPD_OFS_WIN = 8'h28;
    // ----------------------------------------
    // Config field positions
    // ----------------------------------------
    localparam int TPD_CFG_ABORT = 7;
    localparam int TPD_CFG_LATCH = 6;
    // Single enables at 0,2,4; double at 1,3,5
    // ----------------------------------------
    // Source field positions
    // ----------------------------------------
    localparam int TPD_SRC_ANY = 7;
    localparam int TPD_SRC_AX = 4;
    localparam int TPD_SRC_DBL = 3;
    localparam int TPD_SRC_POL = 0;
    // ----------------------------------------
    // Reset values and scaling
    // ----------------------------------------
    localparam logic [7:0] TPD_RST_REG = 8'h00;
    localparam logic [7:0] TPD_RST_WIN = 8'hFF;
    localparam logic [7:0] TPD_THR_MASK = 8'h7F;
    localparam logic [7:0] TPD_MG_PER_LSB = 8'h3F; // 63 mg per count
    localparam logic [1:0] TPD_FS_2G = 2'h0;
    localparam logic [1:0] TPD_FS_4G = 2'h1;
    // ----------------------------------------
    // Detector states
    // ----------------------------------------
    typedef enum logic [2:0] {
        TPD_IDLE,
        TPD_FIRST,
        TPD_LATENCY,
        TPD_WINDOW,
        TPD_SECOND
    } tpd_state_t;
endpackage

// ---- tb/tpd_detector_chk.sv ----
`timescale 1ns/1ns
// --------------------
// Port checker
// --------------------
module tpd_detector_chk
    import tpd_pkg::*;
#(parameter int DATA_W = 14) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sample_valid,
    input wire logic signed [DATA_W-1:0] accel_x,
    input wire logic signed [DATA_W-1:0] accel_y,
    input wire logic signed [DATA_W-1:0] accel_z,
    input wire logic [1:0] accel_full_scale,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic pulse_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Source read, and threshold write then read back
    sequence src_rd;
        reg_rd && reg_addr == TPD_OFS_SRC;
    endsequence
    sequence thx_wr_rd;
        reg_wr && reg_addr == TPD_OFS_THX ##2 reg_rd && reg_addr == TPD_OFS_THX;
    endsequence
    irq_src_a: assert property (src_rd ##0 pulse_irq |=> reg_rdata[TPD_SRC_ANY])
        else $error("source read lost active bit");
    read_clr_a: assert property (src_rd ##0 !sample_valid |=> !pulse_irq)
        else $error("irq stayed after source read");
    irq_cause_a: assert property ($rose(pulse_irq) |-> $past(sample_valid))
        else $error("irq rose without a sample");
    src_ok_a: assert property (src_rd |=> reg_rdata[7] == |reg_rdata[6:4]
        && (reg_rdata[2:0] & ~reg_rdata[6:4]) == 3'h0 && reg_rdata[3] <= reg_rdata[7])
        else $error("source flags inconsistent");
    thr_keep_a: assert property (thx_wr_rd |=> reg_rdata == ($past(reg_wdata, 3) & TPD_THR_MASK))
        else $error("threshold read back wrong");
    unmapped_a: assert property (reg_rd && (reg_addr < TPD_OFS_CFG || reg_addr > TPD_OFS_WIN) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    reset_quiet_a: assert property (disable iff (1'b0) srst |=> reg_rdata == 8'h00 && !pulse_irq)
        else $error("outputs not quiet in reset");
endmodule
bind tpd_detector tpd_detector_chk #(.DATA_W(DATA_W)) u_chk (.clk(clk), .srst(srst),
    .sample_valid(sample_valid), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .accel_full_scale(accel_full_scale), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_irq(pulse_irq));

// ---- tb/tpd_sample_src.sv ----
`timescale 1ns/1ns
// --------------------
// Sample source model
// --------------------
module tpd_sample_src #(parameter int DATA_W = 14) (
    input wire logic clk,
    output logic sample_valid,
    output logic signed [DATA_W-1:0] accel_x,
    output logic signed [DATA_W-1:0] accel_y,
    output logic signed [DATA_W-1:0] accel_z
);
    initial {sample_valid, accel_x, accel_y, accel_z} = '0;
    // One sample per four-cycle period; stale lines show the inverse
    task automatic send(input logic signed [DATA_W-1:0] x, y, z);
        @(posedge clk);
        sample_valid <= 1'b1;
        {accel_x, accel_y, accel_z} <= {x, y, z};
        @(posedge clk);
        sample_valid <= 1'b0;
        {accel_x, accel_y, accel_z} <= ~{x, y, z};
        repeat (2) @(posedge clk);
    endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top
    import tpd_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sv, wr = 1'b0, rd = 1'b0, irq, rd_q = 1'b0;
    logic [1:0] fs = 2'h2;
    logic [7:0] ad = 8'h00, wd = 8'h00, rdata;
    logic signed [13:0] ax, ay, az;
    logic [7:0] q[$];
    logic [31:0] seed = 32'd89308;
    int err_count = 0, total_checks = 0;
    tpd_sample_src src (.clk(clk), .sample_valid(sv), .accel_x(ax), .accel_y(ay), .accel_z(az));
    tpd_detector dut (.clk(clk), .srst(srst), .sample_valid(sv), .accel_x(ax), .accel_y(ay), .accel_z(az),
        .accel_full_scale(fs), .reg_addr(ad), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd),
        .reg_rdata(rdata), .pulse_irq(irq));
    // Clock
    always #5 clk = ~clk;
    function automatic logic [13:0] noise();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 14'($signed(seed[7:0]));
    endfunction
    task automatic chk(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        {ad, wd, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, e);
        @(posedge clk);
        {ad, rd} <= {a, 1'b1};
        q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Pulse above then back to rest, irq and source checked
    task automatic tap(input logic signed [13:0] x, y, input logic [7:0] e);
        src.send(x, y, noise());
        src.send(14'sd0, 14'sd0, noise());
        chk("irq", {7'h00, e[7]}, {7'h00, irq});
        rd_reg(TPD_OFS_SRC, e);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Read data checked one cycle after each read
    always @(posedge clk) begin
        if (rd_q) chk("rdata", q.pop_front(), rdata);
        rd_q <= rd;
    end
    // Watchdog
    initial begin
        #200000;
        err_count++;
        results();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            rd_reg(TPD_OFS_CFG, 8'h00);
            rd_reg(TPD_OFS_SRC, 8'h00);
            rd_reg(8'h30, 8'h00);
            wr_reg(TPD_OFS_THX, 8'hFF);
            rd_reg(TPD_OFS_THX, 8'h7F);
            wr_reg(TPD_OFS_THY, 8'h90);
            rd_reg(TPD_OFS_THY, 8'h10);
            wr_reg(TPD_OFS_THZ, 8'h90);
            rd_reg(TPD_OFS_THZ, 8'h10);
            wr_reg(TPD_OFS_THX, 8'h10);
            wr_reg(TPD_OFS_SRC, 8'hFF);
            if (k == 0) begin
                wr_reg(TPD_OFS_CFG, 8'h01);
                src.send(14'sd2000, 14'sd0, noise());
                src.send(14'sd0, 14'sd0, noise());
                chk("irq", 8'h01, {7'h00, irq});
                src.send(14'sd0, 14'sd0, noise());
                chk("irq", 8'h00, {7'h00, irq});
                srst <= 1'b1;
                repeat (2) @(posedge clk);
                srst <= 1'b0;
            end
        end
        wr_reg(TPD_OFS_CFG, 8'h41);
        tap(14'sd2000, 14'sd0, 8'h90);
        rd_reg(TPD_OFS_SRC, 8'h00);
        tap(14'sd1008, 14'sd0, 8'h00);
        tap(14'sd1009, 14'sd0, 8'h90);
        // Pulse held two samples exceeds the zero time limit
        src.send(14'sd2000, 14'sd0, noise());
        tap(14'sd2000, 14'sd0, 8'h00);
        fs <= 2'h0;
        tap(14'sd2000, 14'sd0, 8'h00);
        fs <= 2'h2;
        wr_reg(TPD_OFS_CFG, 8'h44);
        tap(14'sd0, -14'sd2000, 8'hA2);
        wr_reg(TPD_OFS_CFG, 8'h40);
        tap(14'sd2000, 14'sd0, 8'h00);
        wr_reg(TPD_OFS_LTC, 8'h02);
        wr_reg(TPD_OFS_WIN, 8'h07);
        // Second start inside latency, then a late pulse
        for (int a = 0; a < 2; a++) begin
            wr_reg(TPD_OFS_CFG, a ? 8'hC2 : 8'h42);
            // First pulse, then a start and fall inside latency, then rest into the window
            for (int i = 0; i < 5; i++) begin
                src.send((i == 0 || i == 2) ? 14'sd2000 : 14'sd0, 14'sd0, noise());
            end
            tap(14'sd2000, 14'sd0, a ? 8'h00 : 8'h98);
        end
        results();
    end
endmodule
